// ---- bench/osp_master_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module osp_master_model (
   input  wire logic clk,
   input  wire logic output_update,
   output var  logic sm_event,
   output var  logic cycle_done
);
   logic upd_seen;

   // Idle levels, set from the caller's process
   task automatic idle();
      sm_event   = 1'b0;
      cycle_done = 1'b0;
      upd_seen   = 1'b0;
   endtask

   // One cycle: start, optional early restart, done k clocks later
   task automatic run_cycle(input int k, input bit twice);
      upd_seen = 1'b0;
      sm_event = 1'b1;
      @(negedge clk);
      upd_seen = output_update;
      for (int i = 1; i < k; i++) begin
         sm_event = twice && (i == 1);
         @(negedge clk);
      end
      sm_event   = 1'b0;
      cycle_done = 1'b1;
      @(negedge clk);
      cycle_done = 1'b0;
      repeat (2) @(negedge clk);
   endtask
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic        clk;
   logic        rstn;
   logic [7:0]  entry_sel;
   logic        entry_wr;
   logic        entry_rd;
   logic [31:0] entry_wdata;
   logic [31:0] entry_rdata;
   logic        entry_ack;
   logic        entry_err;
   logic        sm_event;
   logic        cycle_done;
   logic        op_state;
   logic        output_update;
   logic        free_run;
   int          bad_count;
   int          n_checks;
   int          upd_cnt;

   osp_output_sync dut (
      .clk           (clk),
      .rstn          (rstn),
      .entry_sel     (entry_sel),
      .entry_wr      (entry_wr),
      .entry_rd      (entry_rd),
      .entry_wdata   (entry_wdata),
      .entry_rdata   (entry_rdata),
      .entry_ack     (entry_ack),
      .entry_err     (entry_err),
      .sm_event      (sm_event),
      .cycle_done    (cycle_done),
      .op_state      (op_state),
      .output_update (output_update),
      .free_run      (free_run)
   );

   osp_master_model partner (
      .clk           (clk),
      .output_update (output_update),
      .sm_event      (sm_event),
      .cycle_done    (cycle_done)
   );

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic finish_test();
      $display("Checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Called at a falling edge; one request, then wait for its answer
   task automatic acc(input logic wr, input logic [7:0] sel,
                      input logic [31:0] wd, input logic e_err,
                      input logic [31:0] e_rd);
      int n;
      entry_sel   = sel;
      entry_wdata = wd;
      entry_wr    = wr;
      entry_rd    = !wr;
      @(negedge clk);
      entry_wr = 1'b0;
      entry_rd = 1'b0;
      n = 0;
      while (entry_ack !== 1'b1 && n < 4) begin
         @(negedge clk);
         n++;
      end
      if (n == 4) begin
         bad_count++;
         finish_test();
      end else begin
         chk({31'h0, entry_err}, {31'h0, e_err});
         if (!wr) chk(entry_rdata, e_rd);
         @(negedge clk);
      end
   endtask

   task automatic rd(input logic [7:0] sel, input logic [31:0] e);
      acc(1'b0, sel, 32'h0, 1'b0, e);
   endtask

   task automatic wr(input logic [7:0] sel, input logic [31:0] d,
                     input logic e_err);
      acc(1'b1, sel, d, e_err, 32'h0);
   endtask

   initial begin
      bad_count   = 0;
      n_checks    = 0;
      rstn        = 1'b0;
      entry_sel   = 8'h00;
      entry_wr    = 1'b0;
      entry_rd    = 1'b0;
      entry_wdata = 32'h0;
      op_state    = 1'b0;
      partner.idle();
      repeat (10) @(negedge clk);
      rstn = 1'b1;
      @(negedge clk);
      rd(8'h00, 32'h00000020);
      rd(8'h01, 32'h00000001);
      rd(8'h02, 32'h00000000);
      rd(8'h03, 32'h00000000);
      rd(8'h04, 32'h0000c003);
      rd(8'h05, 32'h00000000);
      rd(8'h06, 32'h00000000);
      rd(8'h08, 32'h00000000);
      rd(8'h09, 32'h00000000);
      rd(8'h0b, 32'h00000000);
      rd(8'h0c, 32'h00000000);
      rd(8'h0d, 32'h00000000);
      rd(8'h20, 32'h00000000);
      acc(1'b0, 8'h07, 32'h0, 1'b1, 32'h0);
      wr(8'h04, 32'h00000000, 1'b1);
      rd(8'h04, 32'h0000c003);
      wr(8'h05, 32'h00000064, 1'b1);
      rd(8'h05, 32'h00000000);
      wr(8'h01, 32'h00000002, 1'b1);
      rd(8'h01, 32'h00000001);
      wr(8'h08, 32'h00000002, 1'b1);
      rd(8'h08, 32'h00000000);
      // Free running with a 50 ns local timer
      wr(8'h02, 32'h00000032, 1'b0);
      rd(8'h02, 32'h00000032);
      wr(8'h01, 32'h00000000, 1'b0);
      rd(8'h01, 32'h00000000);
      chk({31'h0, free_run}, 32'h1);
      upd_cnt = 0;
      repeat (100) begin
         @(negedge clk);
         upd_cnt += int'(output_update === 1'b1);
      end
      chk({31'h0, upd_cnt >= 19 && upd_cnt <= 21}, 32'h1);
      wr(8'h01, 32'h00000001, 1'b0);
      @(negedge clk);
      chk({31'h0, free_run}, 32'h0);
      // Measurement keeps the largest cycle
      wr(8'h08, 32'h00000001, 1'b0);
      rd(8'h08, 32'h00000001);
      partner.run_cycle(3, 1'b0);
      chk({31'h0, partner.upd_seen}, 32'h1);
      partner.run_cycle(6, 1'b0);
      partner.run_cycle(4, 1'b0);
      rd(8'h05, 32'h0000003c);
      wr(8'h08, 32'h00000000, 1'b0);
      partner.run_cycle(8, 1'b0);
      rd(8'h05, 32'h0000003c);
      wr(8'h08, 32'h00000001, 1'b0);
      partner.run_cycle(2, 1'b0);
      rd(8'h05, 32'h00000014);
      rd(8'h03, 32'h00000000);
      rd(8'h06, 32'h00000000);
      rd(8'h09, 32'h00000000);
      rd(8'h0c, 32'h00000000);
      // Overruns only while operational
      op_state = 1'b1;
      partner.run_cycle(3, 1'b0);
      rd(8'h0c, 32'h00000000);
      partner.run_cycle(7, 1'b0);
      rd(8'h0c, 32'h00000001);
      partner.run_cycle(4, 1'b1);
      rd(8'h0c, 32'h00000002);
      rd(8'h0b, 32'h00000000);
      rd(8'h0d, 32'h00000000);
      rd(8'h20, 32'h00000000);
      finish_test();
   end
endmodule
`default_nettype wire

// ---- rtl/osp_output_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
module osp_output_sync (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic [7:0]  entry_sel,
   input  wire logic        entry_wr,
   input  wire logic        entry_rd,
   input  wire logic [31:0] entry_wdata,
   output logic      [31:0] entry_rdata,
   output logic             entry_ack,
   output logic             entry_err,
   input  wire logic        sm_event,
   input  wire logic        cycle_done,
   input  wire logic        op_state,
   output logic             output_update,
   output logic             free_run
);

   function automatic logic osp_is_mapped(input logic [7:0] sel);
      case (sel)
         osp_pkg::SEL_HIGHEST_SUBINDEX, osp_pkg::SEL_SYNC_MODE_SELECT,
         osp_pkg::SEL_CYCLE_TIME_NS,    osp_pkg::SEL_FIRST_EVENT_NS,
         osp_pkg::SEL_SUPPORTED_MODES,  osp_pkg::SEL_MINIMUM_CYCLE_NS,
         osp_pkg::SEL_MIN_EVENT_GAP_NS, osp_pkg::SEL_MEAS_COMMAND,
         osp_pkg::SEL_SECOND_EVENT_NS,  osp_pkg::SEL_MISSED_EVENTS,
         osp_pkg::SEL_CYCLE_OVERRUNS,   osp_pkg::SEL_SHORT_GAPS,
         osp_pkg::SEL_LATE_OUTPUT_FLAG: osp_is_mapped = 1'b1;
         default:                       osp_is_mapped = 1'b0;
      endcase
   endfunction

   logic [15:0]          sync_mode_r,   sync_mode_nxt;
   logic [31:0]          cycle_time_r,  cycle_time_nxt;
   logic [15:0]          meas_cmd_r,    meas_cmd_nxt;
   osp_pkg::osp_meas_type meas_st_r,    meas_st_nxt;
   logic [31:0]          min_cycle_r,   min_cycle_nxt;
   logic [15:0]          overrun_r,     overrun_nxt;
   logic [31:0]          timer_r,       timer_nxt;
   logic [31:0]          elapsed_r,     elapsed_nxt;
   logic                 busy_r,        busy_nxt;
   logic [31:0]          rdata_r,       rdata_nxt;
   logic                 ack_r,         ack_nxt;
   logic                 err_r,         err_nxt;
   logic                 update_r,      update_nxt;
   logic                 free_run_r,    free_run_nxt;

   logic                 is_free;
   logic                 tick;
   logic                 cycle_start;
   logic [31:0]          elapsed_inc;
   logic [31:0]          measured;
   logic                 overrun_evt;
   logic                 wr_ok;
   logic                 meas_start;

   assign is_free     = (sync_mode_r == osp_pkg::SYNC_MODE_FREE_RUN);
   // Nonzero cycle times up to one clock tick every clock; zero never ticks; no wrapped limit
   assign tick        = is_free && (cycle_time_r != 32'h00000000) &&
                        (cycle_time_r <= osp_pkg::NS_PER_CLK ||
                         timer_r >= cycle_time_r - osp_pkg::NS_PER_CLK);
   assign cycle_start = is_free ? tick : sm_event;
   assign elapsed_inc = (elapsed_r > osp_pkg::NS_MAX - osp_pkg::NS_PER_CLK) ?
                        osp_pkg::NS_MAX : elapsed_r + osp_pkg::NS_PER_CLK;
   assign measured    = elapsed_inc;
   // Early restart or late completion, counted only in operational state
   assign overrun_evt = op_state && busy_r &&                         // [R13]
                        (cycle_start ||
                         (cycle_done && cycle_time_r != 32'h00000000 &&
                          measured > cycle_time_r));
   assign meas_start  = entry_wr && wr_ok &&
                        entry_sel == osp_pkg::SEL_MEAS_COMMAND &&
                        entry_wdata[15:0] == osp_pkg::MEAS_CMD_START &&
                        meas_st_r == osp_pkg::OSP_MEAS_IDLE;

   always_comb begin
      wr_ok = 1'b0;
      case (entry_sel)
         osp_pkg::SEL_SYNC_MODE_SELECT:
            wr_ok = entry_wdata[31:16] == 16'h0000 &&
                    (entry_wdata[15:0] == osp_pkg::SYNC_MODE_FREE_RUN ||
                     entry_wdata[15:0] == osp_pkg::SYNC_MODE_OUTPUT_SM);
         osp_pkg::SEL_CYCLE_TIME_NS:
            wr_ok = 1'b1;
         osp_pkg::SEL_MEAS_COMMAND:
            wr_ok = entry_wdata[31:16] == 16'h0000 &&
                    (entry_wdata[15:0] == osp_pkg::MEAS_CMD_STOP ||
                     entry_wdata[15:0] == osp_pkg::MEAS_CMD_START);
         default:
            wr_ok = 1'b0;
      endcase
   end

   // Entry access: writes take priority over reads
   always_comb begin
      sync_mode_nxt  = sync_mode_r;
      cycle_time_nxt = cycle_time_r;
      meas_cmd_nxt   = meas_cmd_r;
      meas_st_nxt    = meas_st_r;
      rdata_nxt      = rdata_r;
      ack_nxt        = entry_wr || entry_rd;
      err_nxt        = 1'b0;
      if (entry_wr) begin
         err_nxt = !wr_ok;
         if (wr_ok) begin
            case (entry_sel)
               osp_pkg::SEL_SYNC_MODE_SELECT: begin
                  sync_mode_nxt = entry_wdata[15:0];                  // [R1]
               end
               osp_pkg::SEL_CYCLE_TIME_NS: begin
                  cycle_time_nxt = entry_wdata;                       // [R2]
               end
               osp_pkg::SEL_MEAS_COMMAND: begin
                  meas_cmd_nxt = entry_wdata[15:0];                   // [R5]
                  if (entry_wdata[15:0] == osp_pkg::MEAS_CMD_START) begin
                     meas_st_nxt = osp_pkg::OSP_MEAS_RUN;
                  end else begin
                     meas_st_nxt = osp_pkg::OSP_MEAS_IDLE;
                  end
               end
               default: begin
                  sync_mode_nxt = sync_mode_r;
               end
            endcase
         end
      end else if (entry_rd) begin
         err_nxt   = !osp_is_mapped(entry_sel);
         rdata_nxt = 32'h00000000;
         case (entry_sel)
            osp_pkg::SEL_HIGHEST_SUBINDEX:
               rdata_nxt = 32'(osp_pkg::HIGHEST_SUBINDEX_VAL); // [R16]
            osp_pkg::SEL_SYNC_MODE_SELECT:
               rdata_nxt = {16'h0000, sync_mode_r};
            osp_pkg::SEL_CYCLE_TIME_NS:
               rdata_nxt = cycle_time_r;
            osp_pkg::SEL_SUPPORTED_MODES:
               rdata_nxt = 32'(osp_pkg::SUPPORTED_MODES_VAL); // [R3] [R4]
            osp_pkg::SEL_MINIMUM_CYCLE_NS:
               rdata_nxt = min_cycle_r;                               // [R11]
            osp_pkg::SEL_FIRST_EVENT_NS,
            osp_pkg::SEL_MIN_EVENT_GAP_NS,
            osp_pkg::SEL_SECOND_EVENT_NS:
               rdata_nxt = osp_pkg::DC_TIME_DEFAULT;  // [R8] [R9] [R10] [R17]
            osp_pkg::SEL_MEAS_COMMAND:
               rdata_nxt = {16'h0000, meas_cmd_r};
            osp_pkg::SEL_MISSED_EVENTS,
            osp_pkg::SEL_SHORT_GAPS:
               rdata_nxt = 32'(osp_pkg::COUNTER_RESET); // [R12] [R14] [R17]
            osp_pkg::SEL_CYCLE_OVERRUNS:
               rdata_nxt = {16'h0000, overrun_r};
            osp_pkg::SEL_LATE_OUTPUT_FLAG:
               rdata_nxt = 32'(osp_pkg::LATE_FLAG_DEFAULT); // [R15] [R17]
            default:
               rdata_nxt = 32'h00000000;
         endcase
      end
   end

   // Cycle timing, measurement and overrun counting
   always_comb begin
      timer_nxt     = timer_r;
      elapsed_nxt   = elapsed_r;
      busy_nxt      = busy_r;
      min_cycle_nxt = min_cycle_r;
      overrun_nxt   = overrun_r;
      update_nxt    = cycle_start;
      free_run_nxt  = is_free;
      if (!is_free || cycle_time_r == 32'h00000000 || tick) begin
         timer_nxt = 32'h00000000;
      end else begin
         timer_nxt = timer_r + osp_pkg::NS_PER_CLK;
      end
      if (cycle_start) begin
         busy_nxt    = 1'b1;
         elapsed_nxt = 32'h00000000;
      end else if (cycle_done) begin
         busy_nxt = 1'b0;
      end else if (busy_r) begin
         elapsed_nxt = elapsed_inc;
      end
      if (meas_start) begin
         min_cycle_nxt = 32'h00000000;                                // [R7]
      end else if (meas_st_r == osp_pkg::OSP_MEAS_RUN && busy_r &&
                   cycle_done && measured > min_cycle_r) begin
         min_cycle_nxt = measured;                                    // [R6]
      end
      if (overrun_evt && overrun_r != osp_pkg::COUNTER_MAX) begin     // [R18]
         overrun_nxt = overrun_r + 16'h0001;                          // [R13]
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sync_mode_r  <= osp_pkg::SYNC_MODE_RESET;
         cycle_time_r <= osp_pkg::CYCLE_TIME_RESET;
         meas_cmd_r   <= osp_pkg::MEAS_CMD_RESET;
         meas_st_r    <= osp_pkg::OSP_MEAS_IDLE;
         min_cycle_r  <= osp_pkg::DC_TIME_DEFAULT;
         overrun_r    <= osp_pkg::COUNTER_RESET;
         timer_r      <= 32'h00000000;
         elapsed_r    <= 32'h00000000;
         busy_r       <= 1'b0;
         rdata_r      <= 32'h00000000;
         ack_r        <= 1'b0;
         err_r        <= 1'b0;
         update_r     <= 1'b0;
         free_run_r   <= 1'b0;
      end else begin
         sync_mode_r  <= sync_mode_nxt;
         cycle_time_r <= cycle_time_nxt;
         meas_cmd_r   <= meas_cmd_nxt;
         meas_st_r    <= meas_st_nxt;
         min_cycle_r  <= min_cycle_nxt;
         overrun_r    <= overrun_nxt;
         timer_r      <= timer_nxt;
         elapsed_r    <= elapsed_nxt;
         busy_r       <= busy_nxt;
         rdata_r      <= rdata_nxt;
         ack_r        <= ack_nxt;
         err_r        <= err_nxt;
         update_r     <= update_nxt;
         free_run_r   <= free_run_nxt;
      end
   end

   assign entry_rdata   = rdata_r;
   assign entry_ack     = ack_r;
   assign entry_err     = err_r;
   assign output_update = update_r;
   assign free_run      = free_run_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   property p_sync_mode_write;
      entry_wr && entry_sel == osp_pkg::SEL_SYNC_MODE_SELECT && wr_ok
      |=> {16'h0000, sync_mode_r} == $past(entry_wdata) ##1 free_run ==
          ($past(sync_mode_r) == osp_pkg::SYNC_MODE_FREE_RUN);
   endproperty
   a_sync_mode_write: assert property (p_sync_mode_write) // [R1]
      else $error("sync mode write not taken");

   property p_cycle_time_readback;
      entry_wr && entry_sel == osp_pkg::SEL_CYCLE_TIME_NS ##1
      !entry_wr ##1
      entry_rd && !entry_wr && entry_sel == osp_pkg::SEL_CYCLE_TIME_NS
      |=> entry_rdata == $past(entry_wdata, 3);
   endproperty
   a_cycle_time_readback: assert property (p_cycle_time_readback) // [R2]
      else $error("cycle time readback wrong");

   property p_supported;
      entry_rd && !entry_wr && entry_sel == osp_pkg::SEL_SUPPORTED_MODES
      |=> entry_rdata == 32'h0000c003 && entry_ack && !entry_err;
   endproperty
   a_supported: assert property (p_supported) // [R3]
      else $error("supported modes word wrong");

   property p_meas_cmd;
      entry_wr && entry_sel == osp_pkg::SEL_MEAS_COMMAND && wr_ok
      |=> meas_st_r == ($past(entry_wdata) == 32'h00000001 ?
                        osp_pkg::OSP_MEAS_RUN : osp_pkg::OSP_MEAS_IDLE);
   endproperty
   a_meas_cmd: assert property (p_meas_cmd) // [R5]
      else $error("measurement command not followed");

   property p_max_hold;
      meas_st_r == osp_pkg::OSP_MEAS_RUN && !meas_start
      |=> min_cycle_r >= $past(min_cycle_r);
   endproperty
   a_max_hold: assert property (p_max_hold) // [R6]
      else $error("measured maximum decreased");

   property p_clear_on_start;
      meas_start && min_cycle_r != 32'h00000000 |=> min_cycle_r == 32'h0;
   endproperty
   a_clear_on_start: assert property (p_clear_on_start) // [R7]
      else $error("maximum not cleared on new measurement");

   property p_dc_defaults;
      entry_rd && !entry_wr &&
      (entry_sel == osp_pkg::SEL_FIRST_EVENT_NS ||
       entry_sel == osp_pkg::SEL_SECOND_EVENT_NS ||
       entry_sel == osp_pkg::SEL_MISSED_EVENTS ||
       entry_sel == osp_pkg::SEL_LATE_OUTPUT_FLAG)
      |=> entry_rdata == 32'h00000000;
   endproperty
   a_dc_defaults: assert property (p_dc_defaults) // [R17]
      else $error("distributed clock entry not at default");

   property p_overrun_count;
      overrun_evt && overrun_r != 16'hffff
      |=> overrun_r == $past(overrun_r) + 16'h1;
   endproperty
   a_overrun_count: assert property (p_overrun_count) // [R13]
      else $error("overrun not counted");

   property p_saturate;
      overrun_r == 16'hffff |=> overrun_r == 16'hffff;
   endproperty
   a_saturate: assert property (p_saturate) // [R18]
      else $error("overrun counter wrapped");

   property p_subindex;
      entry_rd && !entry_wr && entry_sel == osp_pkg::SEL_HIGHEST_SUBINDEX
      |=> entry_rdata == 32'h00000020;
   endproperty
   a_subindex: assert property (p_subindex) // [R16]
      else $error("highest subindex wrong");

   property p_refused_mode;
      entry_wr && entry_sel == osp_pkg::SEL_SYNC_MODE_SELECT && !wr_ok
      |=> entry_err && sync_mode_r == $past(sync_mode_r);
   endproperty
   a_refused_mode: assert property (p_refused_mode) // [R1]
      else $error("refused sync mode write changed state");

   property p_sm_update;
      sync_mode_r == osp_pkg::SYNC_MODE_OUTPUT_SM && sm_event
      |=> output_update;
   endproperty
   a_sm_update: assert property (p_sm_update) // [R1]
      else $error("no output update after sync manager event");

   property p_stopped_hold;
      meas_st_r == osp_pkg::OSP_MEAS_IDLE && !meas_start
      |=> min_cycle_r == $past(min_cycle_r);
   endproperty
   a_stopped_hold: assert property (p_stopped_hold) // [R5]
      else $error("measured value changed while stopped");

   property p_no_count_idle;
      !op_state |=> overrun_r == $past(overrun_r);
   endproperty
   a_no_count_idle: assert property (p_no_count_idle) // [R13]
      else $error("overrun counted outside operational state");

   property p_ro_refused;
      entry_wr && entry_sel == osp_pkg::SEL_MINIMUM_CYCLE_NS
      |=> entry_ack && entry_err;
   endproperty
   a_ro_refused: assert property (p_ro_refused) // [R11]
      else $error("write to read-only entry not refused");

   c_free_run_tick: cover property (free_run ##[1:200] output_update);
   c_measure_max: cover property (meas_start ##[1:500]
                                  min_cycle_r != 32'h00000000);
   c_overrun: cover property (overrun_evt);
   c_refused_write: cover property (entry_wr && !wr_ok);

endmodule
`default_nettype wire

// ---- rtl/osp_pkg.sv ----
// Operation
// [R1] Sync mode, read-write: 0 free run, 1 output sync manager; reset 1.
// [R2] Cycle time held in ns, read-write, reset zero.
// [R3] Supported modes word reads 0xc003: free run, sync manager, timing.
// [R4] Supported modes bits 2-5 report distributed clock features.
// [R5] Command entry: 1 starts measurement, 0 stops it; resets to zero.
// [R6] While measuring, measured entries hold the largest values seen.
// [R7] Starting a new measurement first clears earlier maxima.
// [R8] First event to output interval reads in ns, zero by default.
// [R9] Second event to output interval reads in ns.
// [R10] Minimum gap between first and second event reads in ns.
// [R11] Minimum cycle time reads as 32-bit ns value, zero by default.
// [R12] Missed event counter, 16-bit read-only, reset zero.
// [R13] Overrun counter: late cycle end or early start, operational state.
// [R14] Short gap counter, 16-bit read-only.
// [R15] Late output flag, read-only boolean, reset zero.
// [R16] Subindex zero reads highest subindex 0x20.
// [R17] No distributed clock: its entries keep their defaults.
// [R18] Event counters saturate at maximum instead of wrapping.
`default_nettype none
package osp_pkg;

   localparam logic [7:0]  SEL_HIGHEST_SUBINDEX  = 8'h00;
   localparam logic [7:0]  SEL_SYNC_MODE_SELECT  = 8'h01;
   localparam logic [7:0]  SEL_CYCLE_TIME_NS     = 8'h02;
   localparam logic [7:0]  SEL_FIRST_EVENT_NS    = 8'h03;
   localparam logic [7:0]  SEL_SUPPORTED_MODES   = 8'h04;
   localparam logic [7:0]  SEL_MINIMUM_CYCLE_NS  = 8'h05;
   localparam logic [7:0]  SEL_MIN_EVENT_GAP_NS  = 8'h06;
   localparam logic [7:0]  SEL_MEAS_COMMAND      = 8'h08;
   localparam logic [7:0]  SEL_SECOND_EVENT_NS   = 8'h09;
   localparam logic [7:0]  SEL_MISSED_EVENTS     = 8'h0b;
   localparam logic [7:0]  SEL_CYCLE_OVERRUNS    = 8'h0c;
   localparam logic [7:0]  SEL_SHORT_GAPS        = 8'h0d;
   localparam logic [7:0]  SEL_LATE_OUTPUT_FLAG  = 8'h20;

   localparam logic [7:0]  HIGHEST_SUBINDEX_VAL  = 8'h20;
   localparam logic [15:0] SUPPORTED_MODES_VAL   = 16'hc003;
   localparam logic [15:0] SYNC_MODE_FREE_RUN    = 16'h0000;
   localparam logic [15:0] SYNC_MODE_OUTPUT_SM   = 16'h0001;
   localparam logic [15:0] SYNC_MODE_RESET       = 16'h0001;
   localparam logic [31:0] CYCLE_TIME_RESET      = 32'h00000000;
   localparam logic [15:0] MEAS_CMD_STOP         = 16'h0000;
   localparam logic [15:0] MEAS_CMD_START        = 16'h0001;
   localparam logic [15:0] MEAS_CMD_RESET        = 16'h0000;
   localparam logic [31:0] DC_TIME_DEFAULT       = 32'h00000000;
   localparam logic [15:0] COUNTER_RESET         = 16'h0000;
   localparam logic [15:0] COUNTER_MAX           = 16'hffff;
   localparam logic        LATE_FLAG_DEFAULT     = 1'b0;

   localparam int          CLK_PERIOD_NS         = 10;
   localparam logic [31:0] NS_PER_CLK            = 32'(CLK_PERIOD_NS);
   localparam logic [31:0] NS_MAX                = 32'hffffffff;

   typedef enum logic [1:0] {
      OSP_MEAS_IDLE = 2'b00,
      OSP_MEAS_RUN  = 2'b01
   } osp_meas_type;

endpackage
`default_nettype wire
